// file: logic/dsas_pkg.sv
// package: register map, field layout, timing and types of the delta-sigma sequencer
package dsas_pkg;
  localparam logic [7:0] DSAS_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] DSAS_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] DSAS_OFF_TRIM_EN = 8'h08;
  localparam logic [7:0] DSAS_OFF_TRIM_DLY = 8'h0C;
  localparam logic [7:0] DSAS_OFF_PIN_CFG = 8'h10;
  localparam logic [7:0] DSAS_OFF_RESULT = 8'h14;
  localparam logic [7:0] DSAS_OFF_STATUS = 8'h18;

  // converter_control_0 fields
  localparam int DSAS_C0_POWER = 7;
  localparam int DSAS_C0_ENABLE = 6;
  localparam int DSAS_C0_CH_HI = 1;
  localparam int DSAS_C0_CH_LO = 0;
  // converter_control_1 fields
  localparam int DSAS_C1_SINGLE = 0;
  localparam int DSAS_C1_HIACC = 1;
  localparam int DSAS_C1_PARALLEL = 2;
  localparam int DSAS_C1_CNT_HI = 4;
  localparam int DSAS_C1_CNT_LO = 3;
  // trim fields and pin config width
  localparam int DSAS_TE_BIT = 7;
  localparam int DSAS_TD_HI = 6;
  localparam int DSAS_TD_LO = 4;
  localparam int DSAS_PIN_W = 4;
  // status fields
  localparam int DSAS_ST_BUSY = 0;
  localparam int DSAS_ST_SETTLED = 1;
  localparam int DSAS_ST_EARLY = 2;
  localparam int DSAS_ST_PEND = 3;

  localparam logic [7:0] DSAS_CTRL0_RST = 8'h00;
  localparam logic [7:0] DSAS_CTRL1_RST = 8'h00;
  localparam logic [7:0] DSAS_TRIM_EN_RST = 8'h00;
  localparam logic [7:0] DSAS_TRIM_DLY_RST = 8'h20;
  localparam logic [DSAS_PIN_W-1:0] DSAS_PIN_RST = 4'h0;
  localparam logic [2:0] DSAS_DELAY_DEFAULT = 3'h2;
  localparam logic [15:0] DSAS_MIDSCALE = 16'h8000;
  localparam logic [15:0] DSAS_RESULT_RST = 16'h0000;
  localparam int DSAS_PAR_SHIFT = 2;

  localparam int DSAS_CLK_PERIOD_NS = 25;
  localparam int DSAS_PON_SETTLE_NS = 1200;
  localparam int DSAS_PON_SETTLE_CYC =
    (DSAS_PON_SETTLE_NS + DSAS_CLK_PERIOD_NS - 1) / DSAS_CLK_PERIOD_NS;
  localparam int DSAS_TW = 16;

  typedef enum logic [2:0] {
    DSAS_IDLE = 3'h1,
    DSAS_FIRST = 3'h2,
    DSAS_NEXT = 3'h4
  } dsas_state_t;

  typedef struct packed {
    logic power;
    logic single_ended;
    logic high_accuracy;
    logic parallel;
    logic [1:0] channel;
    logic [2:0] delay_code;
    logic [DSAS_PIN_W-1:0] pin_config;
  } dsas_afe_ctl_t;
endpackage

// file: logic/dsas_seq.sv
// delta-sigma converter sequencer: apb registers, power settle, conversion timing, result
//
// The implementer's own choices: the address map and the APB register port.

module dsas_seq
  import dsas_pkg::*;
#(
  parameter int CONV_SERIAL_CYC = 1024
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] sample_code,
  output dsas_afe_ctl_t afe_ctl,
  output logic [15:0] conversion_result,
  output logic conversion_done_irq
);
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [7:0] trim_en_q;
  logic [7:0] trim_dly_q;
  logic [DSAS_PIN_W-1:0] pin_q;
  logic [15:0] result_q;
  logic [15:0] pend_data_q;
  logic pend_q;
  logic discard_q;
  logic settled_q;
  logic early_q;
  logic power_prev_q;
  logic irq_q;
  dsas_state_t state_q;
  dsas_state_t state_d;

  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_pin;
  logic rd_result;
  logic running;
  logic conv_en;
  logic power;
  logic start;
  logic done;
  logic settle_done;
  logic good_end;
  logic [15:0] code;
  logic [DSAS_TW-1:0] full_cyc;
  logic [DSAS_TW-1:0] next_cyc;
  logic [DSAS_TW-1:0] int_load_val;
  logic int_load;
  logic [1:0] cnt_code;

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  always_comb
  begin
    case (paddr)
      DSAS_OFF_CTRL0, DSAS_OFF_CTRL1, DSAS_OFF_TRIM_EN, DSAS_OFF_TRIM_DLY,
      DSAS_OFF_PIN_CFG, DSAS_OFF_RESULT, DSAS_OFF_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = acc && !mapped;
  assign wr_ctrl0 = wr && paddr == DSAS_OFF_CTRL0;
  assign wr_ctrl1 = wr && paddr == DSAS_OFF_CTRL1;
  assign wr_pin = wr && paddr == DSAS_OFF_PIN_CFG;
  assign rd_result = rd && paddr == DSAS_OFF_RESULT;

  assign running = state_q != DSAS_IDLE;
  assign conv_en = ctrl0_q[DSAS_C0_ENABLE];
  assign power = ctrl0_q[DSAS_C0_POWER];

  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      DSAS_OFF_CTRL0: prdata[7:0] = ctrl0_q;
      DSAS_OFF_CTRL1: prdata[7:0] = ctrl1_q;
      DSAS_OFF_TRIM_EN: prdata[7:0] = trim_en_q;
      DSAS_OFF_TRIM_DLY: prdata[7:0] = trim_dly_q;
      DSAS_OFF_PIN_CFG: prdata[DSAS_PIN_W-1:0] = pin_q;
      // the old value is what the bus sees in a colliding cycle
      DSAS_OFF_RESULT: prdata[15:0] = result_q;
      DSAS_OFF_STATUS:
      begin
        prdata[DSAS_ST_BUSY] = running;
        prdata[DSAS_ST_SETTLED] = settled_q;
        prdata[DSAS_ST_EARLY] = early_q;
        prdata[DSAS_ST_PEND] = pend_q;
      end
      default: prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl0_q <= DSAS_CTRL0_RST;
    end
    else if (wr_ctrl0)
    begin
      ctrl0_q <= {pwdata[DSAS_C0_POWER], pwdata[DSAS_C0_ENABLE], 4'h0,
                  pwdata[DSAS_C0_CH_HI:DSAS_C0_CH_LO]};
    end
  end

  // mode changes mid-conversion would corrupt the running result, so they are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl1_q <= DSAS_CTRL1_RST;
    end
    else if (wr_ctrl1 && !running)
    begin
      ctrl1_q <= {3'h0, pwdata[DSAS_C1_CNT_HI:DSAS_C1_CNT_LO], pwdata[DSAS_C1_PARALLEL],
                  pwdata[DSAS_C1_HIACC], pwdata[DSAS_C1_SINGLE]};
    end
  end

  // trim registers are plain storage; sequencing them is software's job
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trim_en_q <= DSAS_TRIM_EN_RST;
      trim_dly_q <= DSAS_TRIM_DLY_RST;
    end
    else if (wr && paddr == DSAS_OFF_TRIM_EN)
    begin
      trim_en_q <= {pwdata[DSAS_TE_BIT], 7'h00};
    end
    else if (wr && paddr == DSAS_OFF_TRIM_DLY)
    begin
      trim_dly_q <= {1'b0, pwdata[DSAS_TD_HI:DSAS_TD_LO], 4'h0};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_q <= DSAS_PIN_RST;
    end
    else if (wr_pin)
    begin
      pin_q <= pwdata[DSAS_PIN_W-1:0];
    end
  end

  // delay code reaches the front end; delay in ns is 2 * (code + 1)
  always_comb
  begin
    afe_ctl.power = power;
    afe_ctl.single_ended = ctrl1_q[DSAS_C1_SINGLE];
    afe_ctl.high_accuracy = ctrl1_q[DSAS_C1_HIACC];
    afe_ctl.parallel = ctrl1_q[DSAS_C1_PARALLEL];
    afe_ctl.channel = ctrl0_q[DSAS_C0_CH_HI:DSAS_C0_CH_LO];
    afe_ctl.pin_config = pin_q;
    if (trim_en_q[DSAS_TE_BIT])
    begin
      afe_ctl.delay_code = trim_dly_q[DSAS_TD_HI:DSAS_TD_LO];
    end
    else
    begin
      afe_ctl.delay_code = DSAS_DELAY_DEFAULT;
    end
  end

  // power settle: counted from the rising edge of the power bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_prev_q <= 1'b0;
    end
    else
    begin
      power_prev_q <= power;
    end
  end

  dsas_timer #(.W(DSAS_TW)) u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .load(power && !power_prev_q),
    .stop(!power),
    .load_val(DSAS_TW'(DSAS_PON_SETTLE_CYC)),
    .expired(settle_done)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settled_q <= 1'b0;
    end
    else if (!power)
    begin
      settled_q <= 1'b0;
    end
    else if (settle_done)
    begin
      settled_q <= 1'b1;
    end
  end

  // an early start is not refused, only flagged so software can drop the result
  assign start = state_q == DSAS_IDLE && conv_en;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      early_q <= 1'b0;
    end
    else if (start)
    begin
      early_q <= !settled_q;
    end
  end

  // interval: sampling count doubles the serial time per step
  assign cnt_code = ctrl1_q[DSAS_C1_CNT_HI:DSAS_C1_CNT_LO];
  assign full_cyc = DSAS_TW'(CONV_SERIAL_CYC) << cnt_code;
  always_comb
  begin
    if (ctrl1_q[DSAS_C1_PARALLEL])
    begin
      next_cyc = full_cyc >> DSAS_PAR_SHIFT;
    end
    else
    begin
      next_cyc = full_cyc;
    end
  end

  // a discarded result restarts timing as a fresh first conversion
  assign int_load = start || (done && conv_en);
  assign int_load_val = (start || !good_end) ? full_cyc : next_cyc;

  dsas_timer #(.W(DSAS_TW)) u_interval (
    .pclk(pclk),
    .presetn(presetn),
    .load(int_load),
    .stop(!conv_en),
    .load_val(int_load_val),
    .expired(done)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DSAS_IDLE:
      begin
        if (conv_en)
        begin
          state_d = DSAS_FIRST;
        end
      end
      DSAS_FIRST, DSAS_NEXT:
      begin
        if (!conv_en)
        begin
          state_d = DSAS_IDLE;
        end
        else if (done)
        begin
          state_d = good_end ? DSAS_NEXT : DSAS_FIRST;
        end
      end
      default: state_d = DSAS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= DSAS_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // pin or channel change while converting taints the result in flight
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      discard_q <= 1'b0;
    end
    else if (start || done)
    begin
      discard_q <= 1'b0;
    end
    else if (running && ((wr_pin && pwdata[DSAS_PIN_W-1:0] != pin_q) ||
             (wr_ctrl0 && pwdata[DSAS_C0_CH_HI:DSAS_C0_CH_LO] !=
              ctrl0_q[DSAS_C0_CH_HI:DSAS_C0_CH_LO])))
    begin
      discard_q <= 1'b1;
    end
  end

  assign good_end = done && !discard_q && !wr_ctrl0 && !wr_pin;

  // differential codes come signed from the modulator; flipping the msb gives offset binary
  always_comb
  begin
    if (ctrl1_q[DSAS_C1_SINGLE])
    begin
      code = sample_code;
    end
    else
    begin
      code = sample_code ^ DSAS_MIDSCALE;
    end
  end

  // a completion that meets a result read is parked one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q <= 1'b0;
      pend_data_q <= DSAS_RESULT_RST;
    end
    else if (good_end && rd_result)
    begin
      pend_q <= 1'b1;
      pend_data_q <= code;
    end
    else
    begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_q <= DSAS_RESULT_RST;
    end
    else if (good_end && !rd_result)
    begin
      result_q <= code;
    end
    else if (pend_q)
    begin
      result_q <= pend_data_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= good_end;
    end
  end

  assign conversion_result = result_q;
  assign conversion_done_irq = irq_q;
endmodule

// file: logic/dsas_timer.sv
// reloadable down-counter that pulses once when its load value has elapsed
module dsas_timer
  import dsas_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic stop,
  input wire logic [W-1:0] load_val,
  output logic expired
);
  logic [W-1:0] count_q;
  logic run_q;

  // load stays out of expiry: the interval caller reloads on expiry, so gating on it would loop
  assign expired = run_q && (count_q == '0) && !stop;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= '0;
      run_q <= 1'b0;
    end
    else if (load)
    begin
      count_q <= load_val - W'(1);
      run_q <= 1'b1;
    end
    else if (stop || (run_q && count_q == '0))
    begin
      run_q <= 1'b0;
    end
    else if (run_q)
    begin
      count_q <= count_q - W'(1);
    end
  end
endmodule

// file: verification/dsas_seq_checker.sv
// checker: sequencing and bus assertions for the sequencer ports
module dsas_seq_checker
  import dsas_pkg::*;
#(
  parameter int CONV_SERIAL_CYC = 1024
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] sample_code,
  input wire dsas_afe_ctl_t afe_ctl,
  input wire logic [15:0] conversion_result,
  input wire logic conversion_done_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic en_q;
  logic te_q;
  logic par_q;
  logic [2:0] dly_q;
  assign acc = psel && penable && pwrite;
  // control 1 mirrored only while the mirrored enable en_q is clear, since busy writes are dropped
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      en_q <= 1'b0;
      te_q <= 1'b0;
      par_q <= 1'b0;
      dly_q <= DSAS_DELAY_DEFAULT;
    end
    else if (acc)
    begin
      if (paddr == DSAS_OFF_CTRL0)
        en_q <= pwdata[DSAS_C0_ENABLE];
      if (paddr == DSAS_OFF_TRIM_EN)
        te_q <= pwdata[DSAS_TE_BIT];
      if (paddr == DSAS_OFF_TRIM_DLY)
        dly_q <= pwdata[DSAS_TD_HI:DSAS_TD_LO];
      if (paddr == DSAS_OFF_CTRL1 && !en_q)
        par_q <= pwdata[DSAS_C1_PARALLEL];
    end
  sequence quiet3;
    !conversion_done_irq [*3];
  endsequence
  sequence quiet8;
    !conversion_done_irq [*8];
  endsequence
  chk_irq_pulse: assert property (conversion_done_irq |=> !conversion_done_irq)
    else $error("done pulse longer than one cycle");
  // a result parked behind a colliding read lands one cycle after its pulse
  chk_result_hold: assert property ($changed(conversion_result) |->
    conversion_done_irq || $past(conversion_done_irq))
    else $error("result changed without completion");
  chk_delay_select: assert property (
    afe_ctl.delay_code == (te_q ? dly_q : DSAS_DELAY_DEFAULT))
    else $error("delay code does not follow trim registers");
  chk_stop_quiet: assert property (!en_q |-> !conversion_done_irq)
    else $error("completion while conversion disabled");
  chk_write_wins: assert property (acc && (paddr == DSAS_OFF_CTRL0 ||
    paddr == DSAS_OFF_PIN_CFG) |=> !conversion_done_irq)
    else $error("completion not suppressed by control write");
  chk_par_gap: assert property (conversion_done_irq && par_q |=> quiet3)
    else $error("parallel results too close");
  chk_ser_gap: assert property (conversion_done_irq && !par_q |=> quiet8)
    else $error("serial results too close");
  chk_first_full: assert property ($rose(en_q) |-> quiet8)
    else $error("first result earlier than serial time");
  chk_bad_addr: assert property (psel && penable && paddr > DSAS_OFF_STATUS |-> pslverr)
    else $error("unmapped access without error");
endmodule

bind dsas_seq dsas_seq_checker #(.CONV_SERIAL_CYC(CONV_SERIAL_CYC)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sample_code(sample_code), .afe_ctl(afe_ctl), .conversion_result(conversion_result),
  .conversion_done_irq(conversion_done_irq));

// file: verification/dsas_seq_test.sv
// testbench: apb-driven directed tests of the sequencer
module dsas_seq_test;
  timeunit 1ns;
  timeprecision 100ps;
  import dsas_pkg::*;
  localparam int N = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, conversion_done_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] sample_code, conversion_result;
  dsas_afe_ctl_t afe_ctl;
  int miscompares, checked, n;
  dsas_seq #(.CONV_SERIAL_CYC(N)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_code(sample_code), .afe_ctl(afe_ctl),
    .conversion_result(conversion_result), .conversion_done_irq(conversion_done_irq));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task test_done;
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    // let the written register settle before callers look at its outputs
    @(negedge pclk);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask
  task wait_irq;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (conversion_done_irq !== 1'b1 && n < 600);
    cmp(conversion_done_irq, 32'h1);
  endtask
  initial
  begin
    #150000;
    miscompares++;
    test_done();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, sample_code} = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(DSAS_OFF_CTRL0, 32'h0);
    rdc(DSAS_OFF_CTRL1, 32'h0);
    rdc(DSAS_OFF_TRIM_EN, 32'h0);
    rdc(DSAS_OFF_TRIM_DLY, 32'h20);
    rdc(DSAS_OFF_PIN_CFG, 32'h0);
    cmp(afe_ctl.delay_code, 32'h2);
    rdc(8'h1C, 32'h0);
    cmp(err, 32'h1);
    wr(DSAS_OFF_RESULT, 32'hFFFF);
    rdc(DSAS_OFF_RESULT, 32'h0);
    wr(DSAS_OFF_TRIM_DLY, 32'h70);
    cmp(afe_ctl.delay_code, 32'h2);
    wr(DSAS_OFF_TRIM_EN, 32'h80);
    for (int i = 0; i < 8; i++)
    begin
      wr(DSAS_OFF_TRIM_DLY, i << 4);
      cmp(afe_ctl.delay_code, i);
    end
    wr(DSAS_OFF_TRIM_EN, 32'h0);
    cmp(afe_ctl.delay_code, 32'h2);
    for (int i = 0; i < 3; i++)
    begin
      wr(DSAS_OFF_CTRL1, 1 << i);
      cmp({afe_ctl.single_ended, afe_ctl.high_accuracy, afe_ctl.parallel}, 4 >> i);
    end
    wr(DSAS_OFF_CTRL1, 32'h0);
    wr(DSAS_OFF_CTRL0, 32'h81);
    cmp({afe_ctl.power, afe_ctl.channel}, 32'h5);
    apb(1'b0, DSAS_OFF_STATUS, 32'h0);
    cmp(rd[DSAS_ST_SETTLED], 32'h0);
    repeat (48) @(posedge pclk);
    apb(1'b0, DSAS_OFF_STATUS, 32'h0);
    cmp(rd[DSAS_ST_SETTLED], 32'h1);
    wr(DSAS_OFF_CTRL0, 32'hC1);
    wait_irq();
    cmp(n >= N && n <= N + 3, 32'h1);
    cmp(conversion_result, 32'h8000);
    sample_code <= 16'h0123;
    wait_irq();
    cmp(n, N);
    cmp(conversion_result, 32'h8123);
    wr(DSAS_OFF_PIN_CFG, 32'h1);
    cmp(afe_ctl.pin_config, 32'h1);
    wait_irq();
    cmp(n + 3, 2 * N);
    wr(DSAS_OFF_CTRL1, 32'h4);
    rdc(DSAS_OFF_CTRL1, 32'h0);
    wait_irq();
    sample_code <= 16'h4444;
    wr(DSAS_OFF_CTRL0, 32'h81);
    repeat (40) @(posedge pclk);
    cmp(conversion_result, 32'h8123);
    wr(DSAS_OFF_CTRL1, 32'h4);
    wr(DSAS_OFF_CTRL0, 32'hC1);
    wait_irq();
    cmp(n >= N && n <= N + 3, 32'h1);
    wait_irq();
    cmp(n, N >> 2);
    wr(DSAS_OFF_CTRL0, 32'h81);
    wr(DSAS_OFF_CTRL1, 32'h8);
    wr(DSAS_OFF_CTRL0, 32'hC1);
    wait_irq();
    wait_irq();
    cmp(n, 2 * N);
    wr(DSAS_OFF_CTRL0, 32'h81);
    wr(DSAS_OFF_CTRL1, 32'h1);
    wr(DSAS_OFF_CTRL0, 32'hC1);
    wait_irq();
    cmp(conversion_result, 32'h4444);
    // the read's access cycle is placed on the next completion cycle
    sample_code <= 16'h5555;
    repeat (12) @(posedge pclk);
    rdc(DSAS_OFF_RESULT, 32'h4444);
    repeat (2) @(posedge pclk);
    cmp(conversion_result, 32'h5555);
    wr(DSAS_OFF_CTRL0, 32'h0);
    wr(DSAS_OFF_CTRL0, 32'h80);
    wr(DSAS_OFF_CTRL0, 32'hC0);
    apb(1'b0, DSAS_OFF_STATUS, 32'h0);
    cmp(rd[DSAS_ST_EARLY], 32'h1);
    wait_irq();
    cmp(n <= N + 3, 32'h1);
    wr(DSAS_OFF_CTRL0, 32'h0);
    test_done();
  end
endmodule
